// >>> rtl/flash_seq_defs.svh
// Constants of the flash program and erase sequencer.
`ifndef FLASH_SEQ_DEFS_SVH
`define FLASH_SEQ_DEFS_SVH

`define OPC_WRITE_ENABLE   8'h06
`define OPC_WRITE_DISABLE  8'h04
`define OPC_PAGE_PROG      8'h02
`define OPC_PAGE_PROG_W    8'h12
`define OPC_QUAD_PROG      8'h32
`define OPC_QUAD_PROG_W    8'h34
`define OPC_SECTOR_ERASE   8'h20
`define OPC_SECTOR_ERASE_W 8'h21
`define OPC_BLK32_ERASE    8'h52
`define OPC_BLK32_ERASE_W  8'h5c
`define OPC_BLK64_ERASE    8'hd8

`define ADDR_BITS_NARROW   6'd24
`define ADDR_BITS_WIDE     6'd32
`define BITS_PER_BYTE      4'd8

`define PAGE_MASK          32'h0000_00ff
`define SECTOR_MASK        32'h0000_0fff
`define BLK32_MASK         32'h0000_7fff
`define BLK64_MASK         32'h0000_ffff
`define PROTECT_UNIT       33'h0_0001_0000
`define ARRAY_TOP          33'h1_0000_0000

`define MCLK_PERIOD_NS     40
`define PROGRAM_CYCLE_TIME_US 700
`define SECTOR_ERASE_TIME_US  50000
`define BLOCK_ERASE_TIME_US   150000

`endif

// >>> rtl/flash_seq_pkg.sv
// Types shared by the flash program and erase sequencer.
package flash_seq_pkg;
	typedef enum logic [2:0] {
		st_idle   = 3'b000,
		st_opcode = 3'b001,
		st_single = 3'b010,
		st_addr   = 3'b011,
		st_data   = 3'b100,
		st_armed  = 3'b101,
		st_ignore = 3'b110
	} cmd_state_t;
	typedef enum logic [1:0] {
		op_program = 2'b00,
		op_sector  = 2'b01,
		op_blk32   = 2'b10,
		op_blk64   = 2'b11
	} op_kind_t;
endpackage

// >>> rtl/page_buf_if.sv
// Signals between the sequencer and its page buffer.
`timescale 1ns/1ps
`default_nettype none
interface page_buf_if;
	logic       clr;
	logic       wr_en;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;
	logic [7:0] rd_addr;
	logic [7:0] rd_data;
	logic       rd_valid;
	modport seq (output clr, output wr_en, output wr_addr, output wr_data,
		output rd_addr, input rd_data, input rd_valid);
	modport buf_side (input clr, input wr_en, input wr_addr, input wr_data,
		input rd_addr, output rd_data, output rd_valid);
endinterface
`default_nettype wire

// >>> rtl/page_buf.sv
// Page buffer of 256 bytes with a per-byte written mark.
`timescale 1ns/1ps
`default_nettype none
module page_buf #(
	parameter int DEPTH = 256
) (
	input  wire logic   mclk,
	input  wire logic   sys_rst,
	input  wire logic   clk_en,
	page_buf_if.buf_side pb
);
	logic [7:0]       mem [DEPTH];
	logic [DEPTH-1:0] written;

	always_ff @(posedge mclk) begin
		if (clk_en && pb.wr_en) begin
			mem[pb.wr_addr] <= pb.wr_data;
		end
	end

	// A later byte to the same slot simply overwrites the earlier one.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			written <= '0;
		end else if (clk_en) begin
			if (pb.clr) begin
				written <= '0;
			end else if (pb.wr_en) begin
				written[pb.wr_addr] <= 1'b1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			pb.rd_data  <= 8'h00;
			pb.rd_valid <= 1'b0;
		end else if (clk_en) begin
			pb.rd_data  <= mem[pb.rd_addr];
			pb.rd_valid <= written[pb.rd_addr];
		end
	end
endmodule
`default_nettype wire

// >>> rtl/flash_seq.sv
// Program and erase command sequencer of a serial NOR flash.
//
// Behaviour
// [RULE1] Opcode 12H programs a page with a 32-bit address in either mode.
// [RULE2] Quad page program uses four lines and needs quad enable set.
// [RULE3] Host sends 32H, three address bytes, then data on the quad lines; the code takes four address bytes for 32H when addr4_mode is set.
// [RULE4] Beyond 256 data bytes, only the last 256 are programmed in the page.
// [RULE5] Fewer than 256 bytes program only those bytes; the rest stay unchanged.
// [RULE6] Program runs only if select rises on a data byte boundary.
// [RULE7] Select rising after a valid program starts a program cycle.
// [RULE8] Busy flag reads 1 during any cycle and 0 afterwards.
// [RULE9] Write enable latch is cleared before each cycle completes.
// [RULE10] Program or erase is refused unless the write enable latch is set.
// [RULE11] Commands aimed at a protected page, sector or block are ignored.
// [RULE12] Opcode 34H is quad program with 32-bit address, needs quad enable.
// [RULE13] Opcode 20H erases the 4KB sector holding the given address.
// [RULE14] Erase runs only if select rises right after the last address bit.
// [RULE15] A valid sector erase starts a sector erase cycle at select rise.
// [RULE16] Opcode 21H is sector erase with a 32-bit address.
// [RULE17] Opcode 52H erases the 32KB block holding the given address.
// [RULE18] Both block erases run a block erase cycle from select rise.
// [RULE19] Opcode 5CH is 32KB block erase with a 32-bit address.
// [RULE20] Opcode D8H erases the 64KB block holding the given address.
// [RULE21] Host holds select low from opcode through the last bit.
// [RULE22] Base erase opcodes take three or four address bytes by mode.
// [RULE23] Data past the page end wraps to the start of the same page.
// [RULE24] While busy, new program or erase commands are refused.
`timescale 1ns/1ps
`default_nettype none
`include "flash_seq_defs.svh"
module flash_seq
	import flash_seq_pkg::*;
#(
	parameter int PROGRAM_CYCLES = (`PROGRAM_CYCLE_TIME_US * 1000) / `MCLK_PERIOD_NS,
	parameter int SECTOR_CYCLES  = (`SECTOR_ERASE_TIME_US * 1000) / `MCLK_PERIOD_NS,
	parameter int BLOCK_CYCLES   = (`BLOCK_ERASE_TIME_US * 1000) / `MCLK_PERIOD_NS
) (
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	input  wire logic        clk_en,
	input  wire logic        cs_n,
	input  wire logic        sck,
	input  wire logic        quad_line_0,
	input  wire logic        quad_line_1,
	input  wire logic        quad_line_2,
	input  wire logic        quad_line_3,
	input  wire logic        addr4_mode,
	input  wire logic        quad_lines_enable,
	input  wire logic        protect_level_bit4,
	input  wire logic        protect_level_bit3,
	input  wire logic        protect_level_bit2,
	input  wire logic        protect_level_bit1,
	input  wire logic        protect_level_bit0,
	input  wire logic [7:0]  prog_rd_addr,
	output logic             busy_cycle_flag,
	output logic             write_enable_latch,
	output logic             op_start,
	output var op_kind_t     op_kind,
	output logic [31:0]      op_addr,
	output logic [7:0]       prog_rd_data,
	output logic             prog_rd_valid
);
	page_buf_if pb ();

	page_buf #(.DEPTH(256)) u_buf (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.clk_en  (clk_en),
		.pb      (pb)
	);

	function automatic logic is_program(input logic [7:0] op);
		return op == `OPC_PAGE_PROG || op == `OPC_PAGE_PROG_W ||
			op == `OPC_QUAD_PROG || op == `OPC_QUAD_PROG_W;
	endfunction

	function automatic logic is_erase(input logic [7:0] op);
		return op == `OPC_SECTOR_ERASE || op == `OPC_SECTOR_ERASE_W ||
			op == `OPC_BLK32_ERASE || op == `OPC_BLK32_ERASE_W ||
			op == `OPC_BLK64_ERASE;
	endfunction

	function automatic logic is_quad(input logic [7:0] op);
		return op == `OPC_QUAD_PROG || op == `OPC_QUAD_PROG_W;
	endfunction

	function automatic logic is_wide(input logic [7:0] op);
		return op == `OPC_PAGE_PROG_W || op == `OPC_QUAD_PROG_W ||
			op == `OPC_SECTOR_ERASE_W || op == `OPC_BLK32_ERASE_W;
	endfunction

	function automatic op_kind_t kind_of(input logic [7:0] op);
		case (op)
			`OPC_SECTOR_ERASE, `OPC_SECTOR_ERASE_W: return op_sector;
			`OPC_BLK32_ERASE, `OPC_BLK32_ERASE_W: return op_blk32;
			`OPC_BLK64_ERASE: return op_blk64;
			default: return op_program;
		endcase
	endfunction

	function automatic logic [31:0] span_of(input op_kind_t k);
		case (k)
			op_sector: return `SECTOR_MASK;
			op_blk32:  return `BLK32_MASK;
			op_blk64:  return `BLK64_MASK;
			default:   return `PAGE_MASK;
		endcase
	endfunction

	// The protected area is the top of the array, 64KB doubled per level step up to the whole array at level 17; levels 18 and up protect nothing.
	function automatic logic is_protected(input logic [31:0] hi, input logic [4:0] lvl);
		logic [32:0] size;
		size = `PROTECT_UNIT << (lvl - 5'd1);
		if (lvl == 5'd0) begin
			return 1'b0;
		end
		if (size >= `ARRAY_TOP) begin
			return 1'b1;
		end
		return {1'b0, hi} >= (`ARRAY_TOP - size);
	endfunction

	// Link pins come from the host's domain and pass two flip-flops first.
	logic [5:0] pin_meta;
	logic [5:0] pin_sync;
	logic       sck_prev;
	logic       cs_prev;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			pin_meta <= 6'h3f;
			pin_sync <= 6'h3f;
			sck_prev <= 1'b1;
			cs_prev  <= 1'b1;
		end else if (clk_en) begin
			pin_meta <= {cs_n, sck, quad_line_3, quad_line_2, quad_line_1, quad_line_0};
			pin_sync <= pin_meta;
			sck_prev <= pin_sync[4];
			cs_prev  <= pin_sync[5];
		end
	end

	logic       cs_low;
	logic       cs_fall;
	logic       cs_rise;
	logic       sck_rise;
	logic [3:0] io_in;

	assign cs_low   = !pin_sync[5];
	assign cs_fall  = cs_prev && !pin_sync[5];
	assign cs_rise  = !cs_prev && pin_sync[5];
	assign sck_rise = cs_low && !sck_prev && pin_sync[4];
	assign io_in    = pin_sync[3:0];

	cmd_state_t  state;
	logic [7:0]  opcode;
	logic [5:0]  bit_cnt;
	logic [5:0]  addr_len;
	logic [31:0] addr;
	logic [7:0]  data_sh;
	logic [7:0]  byte_cnt;
	logic        byte_seen;
	logic [31:0] cycle_cnt;

	logic [7:0]  next_opcode;
	logic [3:0]  step;
	logic [5:0]  next_bits;
	logic [7:0]  next_byte;
	logic        byte_done;
	logic [4:0]  prot_lvl;
	op_kind_t    cmd_kind;
	logic [31:0] target_lo;
	logic        target_prot;
	logic        go_prog;
	logic        go_erase;
	logic        go_cycle;

	assign next_opcode = {opcode[6:0], io_in[0]};
	assign step        = is_quad(opcode) ? 4'd4 : 4'd1; // [RULE2] [RULE12]
	assign next_bits   = bit_cnt + {2'b00, step};
	assign next_byte   = is_quad(opcode) ? {data_sh[3:0], io_in} : {data_sh[6:0], io_in[0]};
	assign byte_done   = state == st_data && sck_rise && next_bits == {2'b00, `BITS_PER_BYTE};
	assign prot_lvl    = {protect_level_bit4, protect_level_bit3, protect_level_bit2,
		protect_level_bit1, protect_level_bit0};
	assign cmd_kind    = kind_of(opcode); // [RULE13] [RULE17] [RULE20]
	assign target_lo   = addr & ~span_of(cmd_kind);
	assign target_prot = is_protected(addr | span_of(cmd_kind), prot_lvl); // [RULE11]

	// Program needs whole bytes and at least one; erase needs select right after addressing.
	assign go_prog  = cs_rise && state == st_data && bit_cnt == 6'd0 && byte_seen &&
		write_enable_latch && !busy_cycle_flag && !target_prot; // [RULE6] [RULE10] [RULE24]
	assign go_erase = cs_rise && state == st_armed && write_enable_latch &&
		!busy_cycle_flag && !target_prot; // [RULE14] [RULE10] [RULE24]
	assign go_cycle = go_prog || go_erase;

	// Command framing; the host keeps select low for the whole command.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state    <= st_idle;
			opcode   <= 8'h00;
			bit_cnt  <= 6'd0;
			addr_len <= `ADDR_BITS_NARROW;
		end else if (clk_en) begin
			if (cs_fall) begin
				state   <= st_opcode;
				bit_cnt <= 6'd0;
			end else if (!cs_low) begin
				state <= st_idle; // [RULE21]
			end else if (sck_rise) begin
				case (state)
					st_opcode: begin
						opcode  <= next_opcode;
						bit_cnt <= bit_cnt + 6'd1;
						if (bit_cnt == 6'd7) begin
							bit_cnt <= 6'd0;
							if (is_wide(next_opcode) || addr4_mode) begin
								addr_len <= `ADDR_BITS_WIDE; // [RULE1] [RULE16] [RULE19] [RULE22]
							end else begin
								addr_len <= `ADDR_BITS_NARROW; // [RULE3] [RULE22]
							end
							if (next_opcode == `OPC_WRITE_ENABLE ||
								next_opcode == `OPC_WRITE_DISABLE) begin
								state <= st_single;
							end else if (busy_cycle_flag) begin
								state <= st_ignore; // [RULE24]
							end else if (is_quad(next_opcode) && !quad_lines_enable) begin
								state <= st_ignore; // [RULE2] [RULE12]
							end else if (is_program(next_opcode) || is_erase(next_opcode)) begin
								state <= st_addr;
							end else begin
								state <= st_ignore;
							end
						end
					end
					st_addr: begin
						bit_cnt <= bit_cnt + 6'd1;
						if (bit_cnt == addr_len - 6'd1) begin
							bit_cnt <= 6'd0;
							state   <= is_program(opcode) ? st_data : st_armed;
						end
					end
					st_data: begin
						bit_cnt <= byte_done ? 6'd0 : next_bits;
					end
					st_single, st_armed: begin
						state <= st_ignore; // [RULE14]
					end
					st_ignore, st_idle: begin
						state <= state;
					end
					default: begin
						state <= st_idle;
					end
				endcase
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			addr <= 32'h0000_0000;
		end else if (clk_en) begin
			if (cs_fall) begin
				addr <= 32'h0000_0000;
			end else if (sck_rise && state == st_addr) begin
				addr <= {addr[30:0], io_in[0]};
			end
		end
	end

	// Data bytes land at the start offset plus count, wrapping in the page.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			data_sh   <= 8'h00;
			byte_cnt  <= 8'h00;
			byte_seen <= 1'b0;
		end else if (clk_en) begin
			if (cs_fall) begin
				byte_cnt  <= 8'h00;
				byte_seen <= 1'b0;
			end else if (sck_rise && state == st_data) begin
				data_sh <= next_byte;
				if (byte_done) begin
					byte_cnt  <= byte_cnt + 8'h01; // [RULE23]
					byte_seen <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			pb.clr     <= 1'b0;
			pb.wr_en   <= 1'b0;
			pb.wr_addr <= 8'h00;
			pb.wr_data <= 8'h00;
		end else if (clk_en) begin
			pb.clr   <= sck_rise && state == st_opcode && bit_cnt == 6'd7 &&
				!busy_cycle_flag && is_program(next_opcode); // [RULE5]
			pb.wr_en <= byte_done; // [RULE4]
			if (byte_done) begin
				pb.wr_addr <= addr[7:0] + byte_cnt; // [RULE23] [RULE4]
				pb.wr_data <= next_byte;
			end
		end
	end

	assign pb.rd_addr = prog_rd_addr;
	assign prog_rd_data  = pb.rd_data;
	assign prog_rd_valid = pb.rd_valid; // [RULE5]

	// Write enable latch; it drops as the self-timed cycle begins.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			write_enable_latch <= 1'b0;
		end else if (clk_en) begin
			if (go_cycle) begin
				write_enable_latch <= 1'b0; // [RULE9]
			end else if (cs_rise && state == st_single && !busy_cycle_flag) begin
				write_enable_latch <= opcode == `OPC_WRITE_ENABLE; // [RULE10]
			end
		end
	end

	// Self-timed cycle: busy for exactly the cycle count of the operation.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			busy_cycle_flag <= 1'b0;
			cycle_cnt       <= 32'h0000_0000;
			op_start        <= 1'b0;
			op_kind         <= op_program;
			op_addr         <= 32'h0000_0000;
		end else if (clk_en) begin
			op_start <= go_cycle;
			if (go_cycle) begin
				busy_cycle_flag <= 1'b1; // [RULE8]
				op_kind         <= cmd_kind;
				op_addr         <= target_lo;
				case (cmd_kind)
					op_program: cycle_cnt <= 32'(PROGRAM_CYCLES - 1); // [RULE7]
					op_sector:  cycle_cnt <= 32'(SECTOR_CYCLES - 1); // [RULE15]
					default:    cycle_cnt <= 32'(BLOCK_CYCLES - 1); // [RULE18]
				endcase
			end else if (busy_cycle_flag) begin
				if (cycle_cnt == 32'h0000_0000) begin
					busy_cycle_flag <= 1'b0; // [RULE8]
				end else begin
					cycle_cnt <= cycle_cnt - 32'h0000_0001;
				end
			end
		end
	end
endmodule
`default_nettype wire

// >>> bench/flash_seq_properties.sv
// Concurrent checks on the ports of the flash sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "flash_seq_defs.svh"
module flash_seq_properties
	import flash_seq_pkg::*;
#(
	parameter int PROGRAM_CYCLES = 20,
	parameter int SECTOR_CYCLES  = 40,
	parameter int BLOCK_CYCLES   = 300
) (
	input wire logic        mclk,
	input wire logic        sys_rst,
	input wire logic        clk_en,
	input wire logic        cs_n,
	input wire logic        busy_cycle_flag,
	input wire logic        write_enable_latch,
	input wire logic        op_start,
	input wire op_kind_t    op_kind,
	input wire logic [31:0] op_addr
);
	logic [31:0] busy_len;
	logic [31:0] exp_len;
	logic [31:0] kind_mask;
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	assign exp_len = (op_kind == op_program) ? 32'(PROGRAM_CYCLES) :
		(op_kind == op_sector) ? 32'(SECTOR_CYCLES) : 32'(BLOCK_CYCLES);
	assign kind_mask = (op_kind == op_program) ? `PAGE_MASK : (op_kind == op_sector) ?
		`SECTOR_MASK : (op_kind == op_blk32) ? `BLK32_MASK : `BLK64_MASK;
	// Counts the busy cycles of the current operation, frozen with the design and cleared when idle.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			busy_len <= '0;
		end else if (clk_en) begin
			if (op_start) begin
				busy_len <= 32'h0000_0001;
			end else if (busy_cycle_flag) begin
				busy_len <= busy_len + 32'h0000_0001;
			end else begin
				busy_len <= '0;
			end
		end
	end
	a_start_pulse: assert property (op_start |=> !op_start)
		else $error("start pulse longer than one cycle");
	a_start_needs_latch: assert property (op_start |-> $past(write_enable_latch))
		else $error("cycle started without write enable");
	a_start_not_busy: assert property (op_start |-> !$past(busy_cycle_flag))
		else $error("cycle started while busy");
	a_start_after_select: assert property (op_start |-> cs_n && $past(cs_n, 2))
		else $error("cycle started while select low");
	a_start_sets_flags: assert property (op_start |-> busy_cycle_flag && !write_enable_latch)
		else $error("flags wrong at cycle start");
	a_busy_rise_cause: assert property ($rose(busy_cycle_flag) |-> op_start)
		else $error("busy rose without start");
	a_busy_exact_len: assert property ($fell(busy_cycle_flag) |-> busy_len == exp_len)
		else $error("busy length wrong");
	a_busy_len_bound: assert property (busy_cycle_flag |-> busy_len <= exp_len)
		else $error("busy runs too long");
	a_addr_aligned: assert property (op_start |-> (op_addr & kind_mask) == 32'h0)
		else $error("target not aligned");
	a_target_held: assert property (!op_start |-> $stable(op_kind) && $stable(op_addr))
		else $error("target changed without start");
endmodule
`default_nettype wire

// >>> bench/host_model.sv
// Host serial controller model driving select, clock and the quad lines.
`timescale 1ns/1ps
`default_nettype none
module host_model (
	output logic       cs_n,
	output logic       sck,
	output logic [3:0] quad
);
	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		quad = 4'h0;
	end
	function automatic logic [7:0] dat(input int n);
		return 8'(n * 7 + n / 256);
	endfunction
	// One link clock period of 320 ns; the clock stays low outside frames.
	task automatic nib(input logic [3:0] v);
		quad = v;
		#160 sck = 1'b1;
		#160 sck = 1'b0;
	endtask
	task automatic bit1(input logic b);
		nib({~b, b, ~b, b});
	endtask
	task automatic frame(input logic [7:0] op, input logic [31:0] a, input int ab, input int nb,
		input logic qd, input int extra);
		int i;
		int k;
		logic [7:0] d;
		cs_n = 1'b0;
		#160;
		for (i = 7; i >= 0; i--) begin
			bit1(op[i]);
		end
		for (i = ab * 8 - 1; i >= 0; i--) begin
			bit1(a[i]);
		end
		for (k = 0; k < nb; k++) begin
			d = dat(k);
			if (qd) begin
				nib(d[7:4]);
				nib(d[3:0]);
			end else begin
				for (i = 7; i >= 0; i--) begin
					bit1(d[i]);
				end
			end
		end
		repeat (extra) bit1(1'b1);
		#160 cs_n = 1'b1;
		quad = ~quad;
	endtask
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
// Testbench of the flash program and erase sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "flash_seq_defs.svh"
module tb_top
	import flash_seq_pkg::*;
;
	typedef struct {logic [7:0] op; logic m4; logic [31:0] a; int nb; op_kind_t k;} row_t;
	logic        mclk;
	logic        sys_rst;
	logic        clk_en;
	logic        cs_n;
	logic        sck;
	logic [3:0]  quad;
	logic        addr4_mode;
	logic        quad_lines_enable;
	logic [4:0]  prot;
	logic [7:0]  prog_rd_addr;
	logic        busy_cycle_flag;
	logic        write_enable_latch;
	logic        op_start;
	op_kind_t    op_kind;
	logic [31:0] op_addr;
	logic [7:0]  prog_rd_data;
	logic        prog_rd_valid;
	logic        seen;
	int          miscompares;
	int          num_checks;
	int          cycles;
	row_t rows[9] = '{'{8'h02, 1'b0, 32'h0012_3456, 2, op_program},
		'{8'h12, 1'b0, 32'h0123_4500, 1, op_program}, '{8'h32, 1'b0, 32'h0000_7710, 3, op_program},
		'{8'h34, 1'b1, 32'h0200_0080, 2, op_program}, '{8'h20, 1'b0, 32'h0045_6789, 0, op_sector},
		'{8'h21, 1'b0, 32'h1234_5678, 0, op_sector}, '{8'h52, 1'b1, 32'h2345_6789, 0, op_blk32},
		'{8'h5c, 1'b0, 32'h3456_789a, 0, op_blk32}, '{8'hd8, 1'b0, 32'h0056_789a, 0, op_blk64}};
	host_model host (.cs_n(cs_n), .sck(sck), .quad(quad));
	flash_seq #(.PROGRAM_CYCLES(20), .SECTOR_CYCLES(40), .BLOCK_CYCLES(300)) uut (
		.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en), .cs_n(cs_n), .sck(sck),
		.quad_line_0(quad[0]), .quad_line_1(quad[1]), .quad_line_2(quad[2]),
		.quad_line_3(quad[3]), .addr4_mode(addr4_mode), .quad_lines_enable(quad_lines_enable),
		.protect_level_bit4(prot[4]), .protect_level_bit3(prot[3]), .protect_level_bit2(prot[2]),
		.protect_level_bit1(prot[1]), .protect_level_bit0(prot[0]), .prog_rd_addr(prog_rd_addr),
		.busy_cycle_flag(busy_cycle_flag), .write_enable_latch(write_enable_latch),
		.op_start(op_start), .op_kind(op_kind), .op_addr(op_addr),
		.prog_rd_data(prog_rd_data), .prog_rd_valid(prog_rd_valid));
	always #20 mclk = ~mclk;
	function automatic logic [31:0] mask(input op_kind_t k);
		case (k)
			op_program: return `PAGE_MASK;
			op_sector:  return `SECTOR_MASK;
			op_blk32:   return `BLK32_MASK;
			default:    return `BLK64_MASK;
		endcase
	endfunction
	function automatic int alen(input logic [7:0] op, input logic m4);
		if (op == 8'h06) begin
			return 0;
		end
		return (m4 || op inside {8'h12, 8'h34, 8'h21, 8'h5c}) ? 4 : 3;
	endfunction
	task automatic end_sim;
		if (miscompares == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmd(input logic [7:0] op, input logic m4, input logic [31:0] a, input int nb,
		input int extra);
		@(posedge mclk);
		#1;
		addr4_mode = m4;
		host.frame(op, a, alen(op, m4), nb, op inside {8'h32, 8'h34}, extra);
		seen = 1'b0;
		repeat (40) begin
			@(posedge mclk);
			#1;
			if (op_start === 1'b1) begin
				seen = 1'b1;
				break;
			end
		end
	endtask
	task automatic idle;
		repeat (400) begin
			if (busy_cycle_flag === 1'b0) break;
			@(posedge mclk);
			#1;
		end
		chk(busy_cycle_flag, 1'b0);
	endtask
	task automatic rd(input logic [7:0] idx, input logic [7:0] d, input logic v);
		@(posedge mclk);
		#1;
		prog_rd_addr = idx;
		@(posedge mclk);
		#1;
		if (v) chk(prog_rd_data, d);
		chk(prog_rd_valid, v);
	endtask
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 60000) begin
			miscompares++;
			end_sim();
		end
	end
	initial begin
		mclk = 1'b0;
		sys_rst = 1'b1;
		clk_en = 1'b1;
		addr4_mode = 1'b0;
		quad_lines_enable = 1'b1;
		prot = 5'h00;
		prog_rd_addr = 8'h00;
		miscompares = 0;
		num_checks = 0;
		cycles = 0;
		repeat (8) @(posedge mclk);
		#1;
		sys_rst = 1'b0;
		chk(busy_cycle_flag, 1'b0);
		foreach (rows[i]) begin
			cmd(8'h06, 1'b0, 32'h0, 0, 0);
			chk(write_enable_latch, 1'b1);
			cmd(rows[i].op, rows[i].m4, rows[i].a, rows[i].nb, 0);
			chk(seen, 1'b1);
			chk(op_kind, rows[i].k);
			chk(op_addr, rows[i].a & ~mask(rows[i].k));
			chk(busy_cycle_flag, 1'b1);
			chk(write_enable_latch, 1'b0);
			if (rows[i].nb > 0) begin
				rd(rows[i].a[7:0], host.dat(0), 1'b1);
				rd(rows[i].a[7:0] + 8'(rows[i].nb), 8'h00, 1'b0);
			end
			idle();
		end
		cmd(8'h20, 1'b0, 32'h1000, 0, 0);
		chk(seen, 1'b0);
		cmd(8'h06, 1'b0, 32'h0, 0, 0);
		cmd(8'h02, 1'b0, 32'h100, 1, 3);
		chk(seen, 1'b0);
		cmd(8'h02, 1'b0, 32'h100, 0, 0);
		chk(seen, 1'b0);
		cmd(8'h20, 1'b0, 32'h1000, 0, 1);
		chk(seen, 1'b0);
		quad_lines_enable = 1'b0;
		cmd(8'h34, 1'b0, 32'h100, 1, 0);
		chk(seen, 1'b0);
		quad_lines_enable = 1'b1;
		prot = 5'h01;
		cmd(8'h21, 1'b0, 32'hffff_0000, 0, 0);
		chk(seen, 1'b0);
		chk(write_enable_latch, 1'b1);
		cmd(8'h21, 1'b0, 32'hfffe_f000, 0, 0);
		chk(seen, 1'b1);
		idle();
		prot = 5'h0e;
		cmd(8'h06, 1'b0, 32'h0, 0, 0);
		cmd(8'h21, 1'b0, 32'he000_1000, 0, 0);
		chk(seen, 1'b0);
		cmd(8'h21, 1'b0, 32'hdfff_f000, 0, 0);
		chk(seen, 1'b1);
		idle();
		prot = 5'h11;
		cmd(8'h06, 1'b0, 32'h0, 0, 0);
		cmd(8'h12, 1'b0, 32'h0000_0000, 1, 0);
		chk(seen, 1'b0);
		prot = 5'h00;
		cmd(8'h06, 1'b0, 32'h0, 0, 0);
		cmd(8'h52, 1'b0, 32'h8000, 0, 0);
		cmd(8'h06, 1'b0, 32'h0, 0, 0);
		chk(write_enable_latch, 1'b0);
		chk(busy_cycle_flag, 1'b1);
		idle();
		cmd(8'h06, 1'b0, 32'h0, 0, 0);
		cmd(8'h20, 1'b0, 32'h2000, 0, 0);
		chk(seen, 1'b1);
		@(posedge mclk);
		#1;
		// A frozen clock must stretch the erase beyond its normal length.
		clk_en = 1'b0;
		repeat (60) @(posedge mclk);
		#1;
		chk(busy_cycle_flag, 1'b1);
		clk_en = 1'b1;
		repeat (4) @(posedge mclk);
		#1;
		sys_rst = 1'b1;
		repeat (2) @(posedge mclk);
		#1;
		sys_rst = 1'b0;
		chk(busy_cycle_flag, 1'b0);
		chk(write_enable_latch, 1'b0);
		chk(op_start, 1'b0);
		cmd(8'h06, 1'b0, 32'h0, 0, 0);
		cmd(8'h32, 1'b0, 32'h33ff, 258, 0);
		chk(seen, 1'b1);
		chk(op_addr, 32'h3300);
		rd(8'hff, host.dat(256), 1'b1);
		rd(8'h00, host.dat(257), 1'b1);
		rd(8'h01, host.dat(2), 1'b1);
		idle();
		end_sim();
	end
endmodule
bind flash_seq flash_seq_properties #(.PROGRAM_CYCLES(PROGRAM_CYCLES),
	.SECTOR_CYCLES(SECTOR_CYCLES), .BLOCK_CYCLES(BLOCK_CYCLES)) u_props (.mclk(mclk),
	.sys_rst(sys_rst), .clk_en(clk_en), .cs_n(cs_n), .busy_cycle_flag(busy_cycle_flag),
	.write_enable_latch(write_enable_latch), .op_start(op_start), .op_kind(op_kind),
	.op_addr(op_addr));
`default_nettype wire
